// ==== shared/eeprom_pkg.sv ====
package eeprom_pkg;

  // Location of the control port in the indirectly addressed register space.
  localparam logic [7:0] PORT_OFFSET    = 8'h40;
  localparam logic [7:0] PORT_RESET     = 8'h00;

  // Bit positions inside the control port.
  localparam int         SEL_BIT        = 4;
  localparam int         CLK_BIT        = 5;
  localparam int         DIN_BIT        = 6;
  localparam int         DOUT_BIT       = 7;
  localparam logic [3:0] UNUSED_BITS    = 4'h0;

  // Array geometry.
  localparam int         WORDS          = 256;
  localparam int         AW             = 8;
  localparam int         DW             = 8;
  localparam logic [7:0] ERASED_WORD    = 8'hFF;
  localparam logic [7:0] ADDR_STEP      = 8'h01;

  // Frame layout: start bit, then opcode and address shift as an 11-bit head.
  localparam int         HEAD_BITS      = 11;
  localparam logic [3:0] HEAD_LAST      = 4'hA;
  localparam logic [3:0] DATA_LAST      = 4'h7;
  localparam logic [3:0] BIT_STEP       = 4'h1;
  localparam logic [3:0] CNT_ZERO       = 4'h0;

  // Opcodes and the special-command selectors carried in the top address bits.
  localparam logic [1:0] OP_SPECIAL     = 2'h0;
  localparam logic [1:0] OP_WRITE       = 2'h1;
  localparam logic [1:0] OP_READ        = 2'h2;
  localparam logic [1:0] OP_ERASE       = 2'h3;
  localparam logic [1:0] SP_DISABLE     = 2'h0;
  localparam logic [1:0] SP_WRITE_ALL   = 2'h1;
  localparam logic [1:0] SP_ERASE_ALL   = 2'h2;
  localparam logic [1:0] SP_ENABLE      = 2'h3;

  // Self-timed programming cycle, counted on the link clock.
  localparam int         PROG_TIME_NS   = 2000000;
  localparam int         LINK_PERIOD_NS = 160;
  localparam int         PROG_CYCLES    = PROG_TIME_NS / LINK_PERIOD_NS;
  localparam int         TIMER_W        = 16;
  localparam logic [15:0] TIMER_ZERO    = 16'h0000;
  localparam logic [15:0] TIMER_STEP    = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HEAD,
    ST_DATA,
    ST_READ,
    ST_HOLD,
    ST_BUSY
  } frame_state_t;

  typedef enum logic [2:0] {
    PD_NONE,
    PD_WORD,
    PD_ALL,
    PD_ENABLE,
    PD_DISABLE
  } pending_t;

endpackage

// ==== hw/serial_eeprom_data_port.sv ====
// Overview of operation
// - Array of 256 eight-bit nonvolatile words; flip-flops here, erased to all ones on each reset.
// - Frame: start one, opcode, nine address, data.
// - Serial-in captured on rising clock while selected.
// - Serial-out reads high whenever select is low.
// - Programming disabled after power-on reset.
// - Programming commands ignored unless enabled.
// - Enable holds until disable command or reset.
// - Read sends dummy zero, then eight bits.
// - Read works whether programming enabled or not.
// - Address increments after each word read.
// - Sequential read wraps until select drops.
// - Word erase starts on select falling.
// - Serial-out low while busy, high when done.
// - Word write starts on select falling.
// - Word write erases target word first itself.
// - Erase-all sets every bit to one.
// - Write-all programs data into every word.
// - Opcodes: read 10, erase 11, write 01.
// - Opcode 00 specials chosen by top address bits.
// - Port bits: select, clock, in, out.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_data_port
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       link_clk,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rd_data
);

  // ---------------- System clock side ----------------

  // Software-written port bits, packed as {serial_in, serial_clock, select}.
  logic [2:0]     port_bits_reg;
  logic [2:0]     port_bits_next;
  logic           serial_out_meta_reg;
  logic           serial_out_sync_reg;
  logic [7:0]     rd_data_next;
  logic           port_hit;
  logic           port_wr_hit;
  logic           select_bit;
  logic           serial_clock_bit;
  logic           serial_in_bit;
  logic           serial_out_bit;
  logic           dout_reg;

  // Decode of the single control port; the CPU only ever reaches it indirectly.
  assign port_hit         = (reg_addr == PORT_OFFSET);
  assign port_wr_hit      = reg_wr && port_hit;
  assign port_bits_next   = port_wr_hit ? {reg_wdata[DIN_BIT], reg_wdata[CLK_BIT], reg_wdata[SEL_BIT]}
                                        : port_bits_reg;
  assign select_bit       = port_bits_reg[0];
  assign serial_clock_bit = port_bits_reg[1];
  assign serial_in_bit    = port_bits_reg[2];

  // The out bit is forced high as soon as select is cleared, without waiting on the crossing.
  assign serial_out_bit   = select_bit ? serial_out_sync_reg : 1'b1;
  assign rd_data_next     = port_hit ? {serial_out_bit, serial_in_bit, serial_clock_bit, select_bit, UNUSED_BITS}
                                     : PORT_RESET;

  // Port bits are stored here and only here; the link side sees synchronised copies.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_bits_reg <= PORT_RESET[2:0];
    end else begin
      port_bits_reg <= port_bits_next;
    end
  end

  // Read data is registered, one cycle behind the address; other addresses read zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data <= PORT_RESET;
    end else begin
      reg_rd_data <= rd_data_next;
    end
  end

  // Serial-out level comes back from the link domain through two flip-flops.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_out_meta_reg <= 1'b1;
      serial_out_sync_reg <= 1'b1;
    end else begin
      serial_out_meta_reg <= dout_reg;
      serial_out_sync_reg <= serial_out_meta_reg;
    end
  end

  // ---------------- Link clock side ----------------

  logic           rst_link_meta_reg;
  logic           rst_link_reg;
  logic [2:0]     link_meta_reg;
  logic [2:0]     link_sync_reg;
  logic [2:0]     link_prev_reg;
  logic           sel_now;
  logic           di_now;
  logic           sk_rise;

  frame_state_t   state_reg;
  frame_state_t   state_next;
  pending_t       pend_reg;
  pending_t       pend_next;
  logic [3:0]     cnt_reg;
  logic [3:0]     cnt_next;
  logic [HEAD_BITS-1:0] head_reg;
  logic [HEAD_BITS-1:0] head_next;
  logic [DW-1:0]  data_reg;
  logic [DW-1:0]  data_next;
  logic [DW-1:0]  out_reg;
  logic [DW-1:0]  out_next;
  logic [AW-1:0]  addr_reg;
  logic [AW-1:0]  addr_next;
  logic           en_reg;
  logic           en_next;
  logic           dout_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic [DW-1:0]  mem_reg [WORDS];
  logic           commit;
  logic [HEAD_BITS-1:0] head_shift;
  logic [1:0]     head_op;
  logic [1:0]     head_special;
  logic [AW-1:0]  head_addr;
  logic [AW-1:0]  addr_inc;
  logic [TIMER_W-1:0] timer_load;

  // Reset for the link domain asserts at once and releases on a link clock edge.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      rst_link_meta_reg <= 1'b1;
      rst_link_reg      <= 1'b1;
    end else begin
      rst_link_meta_reg <= 1'b0;
      rst_link_reg      <= rst_link_meta_reg;
    end
  end

  // Two-stage synchroniser for the port bits, plus a third stage for edge detection.
  // Only the second stage and later are looked at, so no logic reads a metastable value.
  always_ff @(posedge link_clk or posedge rst_link_reg) begin
    if (rst_link_reg) begin
      link_meta_reg <= PORT_RESET[2:0];
      link_sync_reg <= PORT_RESET[2:0];
      link_prev_reg <= PORT_RESET[2:0];
    end else begin
      link_meta_reg <= port_bits_reg;
      link_sync_reg <= link_meta_reg;
      link_prev_reg <= link_sync_reg;
    end
  end

  assign sel_now      = link_sync_reg[0];
  assign di_now       = link_sync_reg[2];
  assign sk_rise      = link_sync_reg[1] && !link_prev_reg[1];
  assign head_shift   = {head_reg[HEAD_BITS-2:0], di_now};
  assign head_op      = head_shift[HEAD_BITS-1 -: 2];
  assign head_special = head_shift[AW -: 2];
  assign head_addr    = head_shift[AW-1:0];
  assign addr_inc     = addr_reg + ADDR_STEP;
  assign timer_load   = TIMER_W'(PROG_CYCLES_P - 1);
  assign commit       = (state_reg == ST_BUSY) && (timer_reg == TIMER_ZERO);

  // Frame decoder. Select low always ends a frame; a complete programming
  // frame turns that into the start of the self-timed cycle while programming is enabled.
  always_comb begin
    state_next = state_reg;
    pend_next  = pend_reg;
    cnt_next   = cnt_reg;
    head_next  = head_reg;
    data_next  = data_reg;
    out_next   = out_reg;
    addr_next  = addr_reg;
    en_next    = en_reg;
    dout_next  = dout_reg;
    timer_next = timer_reg;
    case (state_reg)
      ST_IDLE: begin
        dout_next = 1'b1;
        // Leading zeros are skipped; the first one seen is the start bit.
        if (sel_now && sk_rise && di_now) begin
          state_next = ST_HEAD;
          cnt_next   = CNT_ZERO;
        end
      end
      ST_HEAD: begin
        if (!sel_now) begin
          state_next = ST_IDLE;
        end else if (sk_rise) begin
          head_next = head_shift;
          cnt_next  = cnt_reg + BIT_STEP;
          if (cnt_reg == HEAD_LAST) begin
            addr_next = head_addr;
            cnt_next  = CNT_ZERO;
            case (head_op)
              OP_READ: begin
                // Reads ignore the enable state entirely.
                state_next = ST_READ;
                out_next   = mem_reg[head_addr];
                dout_next  = 1'b0;
              end
              OP_ERASE: begin
                state_next = ST_HOLD;
                pend_next  = PD_WORD;
                data_next  = ERASED_WORD;
              end
              OP_WRITE: begin
                state_next = ST_DATA;
                pend_next  = PD_WORD;
              end
              default: begin
                case (head_special)
                  SP_ENABLE: begin
                    state_next = ST_HOLD;
                    pend_next  = PD_ENABLE;
                  end
                  SP_DISABLE: begin
                    state_next = ST_HOLD;
                    pend_next  = PD_DISABLE;
                  end
                  SP_ERASE_ALL: begin
                    state_next = ST_HOLD;
                    pend_next  = PD_ALL;
                    data_next  = ERASED_WORD;
                  end
                  default: begin
                    state_next = ST_DATA;
                    pend_next  = PD_ALL;
                  end
                endcase
              end
            endcase
          end
        end
      end
      ST_DATA: begin
        // A frame cut short before its data byte is dropped.
        if (!sel_now) begin
          state_next = ST_IDLE;
          pend_next  = PD_NONE;
        end else if (sk_rise) begin
          data_next = {data_reg[DW-2:0], di_now};
          cnt_next  = cnt_reg + BIT_STEP;
          if (cnt_reg == DATA_LAST) begin
            state_next = ST_HOLD;
          end
        end
      end
      ST_READ: begin
        if (!sel_now) begin
          state_next = ST_IDLE;
          dout_next  = 1'b1;
        end else if (sk_rise) begin
          dout_next = out_reg[DW-1];
          out_next  = {out_reg[DW-2:0], 1'b0};
          cnt_next  = cnt_reg + BIT_STEP;
          if (cnt_reg == DATA_LAST) begin
            // Preload the next word so streaming continues with no dummy bit.
            cnt_next  = CNT_ZERO;
            addr_next = addr_inc;
            out_next  = mem_reg[addr_inc];
          end
        end
      end
      ST_HOLD: begin
        // Extra clocks are ignored; the command acts once select drops.
        if (!sel_now) begin
          state_next = ST_IDLE;
          pend_next  = PD_NONE;
          case (pend_reg)
            PD_ENABLE: begin
              en_next = 1'b1;
            end
            PD_DISABLE: begin
              en_next = 1'b0;
            end
            PD_WORD, PD_ALL: begin
              if (en_reg) begin
                state_next = ST_BUSY;
                pend_next  = pend_reg;
                timer_next = timer_load;
                dout_next  = 1'b0;
              end
            end
            default: begin
              pend_next = PD_NONE;
            end
          endcase
        end
      end
      ST_BUSY: begin
        // No frame is decoded here, whatever software clocks in.
        dout_next = 1'b0;
        if (timer_reg == TIMER_ZERO) begin
          state_next = ST_IDLE;
          pend_next  = PD_NONE;
          dout_next  = 1'b1;
        end else begin
          timer_next = timer_reg - TIMER_STEP;
        end
      end
      default: begin
        state_next = ST_IDLE;
        pend_next  = PD_NONE;
      end
    endcase
  end

  // Frame state registers; the enable flag clears on every reset.
  always_ff @(posedge link_clk or posedge rst_link_reg) begin
    if (rst_link_reg) begin
      state_reg <= ST_IDLE;
      pend_reg  <= PD_NONE;
      cnt_reg   <= CNT_ZERO;
      head_reg  <= '0;
      data_reg  <= ERASED_WORD;
      out_reg   <= ERASED_WORD;
      addr_reg  <= '0;
      en_reg    <= 1'b0;
      dout_reg  <= 1'b1;
      timer_reg <= TIMER_ZERO;
    end else begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      cnt_reg   <= cnt_next;
      head_reg  <= head_next;
      data_reg  <= data_next;
      out_reg   <= out_next;
      addr_reg  <= addr_next;
      en_reg    <= en_next;
      dout_reg  <= dout_next;
      timer_reg <= timer_next;
    end
  end

  // Storage array. A word write simply replaces the old byte, which is the
  // same as an erase followed by programming, so no erase is needed first.
  // Flip-flops cannot keep data over a reset; the array powers up erased.
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    logic hit;
    assign hit = commit && ((pend_reg == PD_ALL) || (addr_reg == AW'(i)));
    always_ff @(posedge link_clk or posedge rst_link_reg) begin
      if (rst_link_reg) begin
        mem_reg[i] <= ERASED_WORD;
      end else if (hit) begin
        mem_reg[i] <= data_reg;
      end
    end
  end

endmodule

`default_nettype wire

// ==== test/port_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// Software side of the port: it reaches the block only by poking the control register.
module port_master
  import eeprom_pkg::*;
(
  input  wire logic       sys_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  // The pointer rests on the port so its read-back stays live.
  initial begin
    reg_addr  = PORT_OFFSET;
    reg_wr    = 1'h0;
    reg_wdata = 8'h00;
  end
  // One register write, launched and dropped on falling edges.
  task automatic poke(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wr    = 1'h1;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr    = 1'h0;
    reg_addr  = PORT_OFFSET;
  endtask
  // Each step stands several link clocks, so the slow side sees every one.
  task automatic port(input logic sel, input logic clk, input logic din);
    poke(PORT_OFFSET, {1'h0, din, clk, sel, 4'h0});
    repeat (80) @(negedge sys_clk);
  endtask
  // Serial-in is set one write ahead of the rising serial clock, MSB first.
  task automatic shift(input logic [11:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      port(1'h1, 1'h0, bits[i]);
      port(1'h1, 1'h1, bits[i]);
    end
  endtask
  // Select high, then start bit, opcode and nine address bits.
  task automatic start(input logic [1:0] op, input logic [8:0] a);
    port(1'h1, 1'h0, 1'h0);
    shift({1'h1, op, a}, 12);
  endtask
  // Dropping select is what lets a command take effect.
  task automatic stop();
    port(1'h0, 1'h0, 1'h0);
  endtask
endmodule
`default_nettype wire

// ==== test/serial_eeprom_data_port_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// Read-back and serial-out relations seen at the register port.
module serial_eeprom_data_port_sva
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       link_clk,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rd_data
);
  localparam int FALL_LIMIT = 100;
  logic [7:0] quiet_reg;
  logic [7:0] quiet_next;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Cycles since the last port write; it saturates so a long idle never wraps.
  assign quiet_next = (reg_wr && reg_addr == PORT_OFFSET) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hFF};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_reg <= 8'h00;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  sequence port_write;
    reg_wr && reg_addr == PORT_OFFSET;
  endsequence
  sequence port_view;
    !reg_wr && reg_addr == PORT_OFFSET;
  endsequence
  sequence fall_seen;
    $past(reg_addr) == PORT_OFFSET && $past(reg_addr, 2) == PORT_OFFSET && $fell(reg_rd_data[DOUT_BIT]);
  endsequence
  a_unused_zero: assert property (reg_rd_data[3:0] == UNUSED_BITS)
    else $error("unused port bits not zero");
  a_other_zero: assert property ($past(reg_addr) != PORT_OFFSET |-> reg_rd_data == 8'h00)
    else $error("other address read not zero");
  a_port_echo: assert property (port_write ##1 reg_addr == PORT_OFFSET
    |=> reg_rd_data[6:4] == $past(reg_wdata[6:4], 2)) else $error("port bits not written");
  a_port_hold: assert property (port_view ##1 reg_addr == PORT_OFFSET |=> $stable(reg_rd_data[6:4]))
    else $error("port bits moved without a write");
  a_stray_write: assert property (port_view ##1 reg_wr && reg_addr != PORT_OFFSET ##1 port_view
    |=> reg_rd_data[6:4] == $past(reg_rd_data[6:4], 2)) else $error("stray write reached the port");
  a_idle_high: assert property (!$past(rst) && $past(reg_addr) == PORT_OFFSET && !reg_rd_data[SEL_BIT]
    |-> reg_rd_data[DOUT_BIT]) else $error("serial out low while deselected");
  a_fall_selected: assert property (fall_seen |-> reg_rd_data[SEL_BIT])
    else $error("serial out fell while deselected");
  a_fall_cause: assert property (fall_seen |-> quiet_reg < FALL_LIMIT)
    else $error("serial out fell with no recent port step");
endmodule
bind serial_eeprom_data_port serial_eeprom_data_port_sva #(
  .PROG_CYCLES_P(PROG_CYCLES_P)
) sva_u (
  .sys_clk    (sys_clk),
  .rst        (rst),
  .link_clk   (link_clk),
  .reg_addr   (reg_addr),
  .reg_wr     (reg_wr),
  .reg_wdata  (reg_wdata),
  .reg_rd_data(reg_rd_data)
);
`default_nettype wire

// ==== test/serial_eeprom_data_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_data_port_tb
  import eeprom_pkg::*;
;
  localparam int PROG_SIM = 200;
  logic            sys_clk;
  logic            link_clk;
  logic            rst;
  wire logic [7:0] reg_addr;
  wire logic       reg_wr;
  wire logic [7:0] reg_wdata;
  wire logic [7:0] reg_rd_data;
  int              fail_count;
  int              checks_done;
  // The link clock runs sixteen times slower, offset so its edges never meet a system clock edge.
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'h0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  serial_eeprom_data_port #(
    .PROG_CYCLES_P(PROG_SIM)
  ) dut_u (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .link_clk   (link_clk),
    .reg_addr   (reg_addr),
    .reg_wr     (reg_wr),
    .reg_wdata  (reg_wdata),
    .reg_rd_data(reg_rd_data)
  );
  port_master pm_u (
    .sys_clk  (sys_clk),
    .reg_addr (reg_addr),
    .reg_wr   (reg_wr),
    .reg_wdata(reg_wdata)
  );
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic command(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d, input logic with_data);
    pm_u.start(op, a);
    if (with_data) begin
      pm_u.shift({4'h0, d}, 8);
    end
    pm_u.stop();
  endtask
  // Bounded polling, so a status stuck at busy is reported instead of hanging.
  task automatic wait_ready();
    int polls;
    polls = 0;
    pm_u.port(1'h1, 1'h0, 1'h0);
    cmp_bit("busy status", 1'h0, reg_rd_data[DOUT_BIT]);
    while (reg_rd_data[DOUT_BIT] !== 1'h1 && polls < 100) begin
      pm_u.port(1'h1, 1'h0, 1'h0);
      polls++;
    end
    cmp_bit("ready status", 1'h1, reg_rd_data[DOUT_BIT]);
    pm_u.port(1'h0, 1'h0, 1'h0);
  endtask
  task automatic read_check(input logic [7:0] a, input int n, input logic [23:0] exp);
    logic [7:0] w;
    pm_u.start(OP_READ, {1'h0, a});
    cmp_bit("dummy bit", 1'h0, reg_rd_data[DOUT_BIT]);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        pm_u.port(1'h1, 1'h0, 1'h0);
        pm_u.port(1'h1, 1'h1, 1'h0);
        w = {w[6:0], reg_rd_data[DOUT_BIT]};
      end
      cmp_byte("read word", exp[23 - 8 * k -: 8], w);
    end
    pm_u.stop();
  endtask
  // Deselected port reads only the forced-high output; stray and junk writes change nothing.
  task automatic t_reset_state();
    cmp_byte("port after reset", 8'h80, reg_rd_data);
    pm_u.poke(8'h41, 8'h70);
    pm_u.poke(PORT_OFFSET, 8'h8F);
    repeat (4) @(negedge sys_clk);
    cmp_byte("port after junk", 8'h80, reg_rd_data);
  endtask
  task automatic t_locked();
    command(OP_WRITE, 9'h005, 8'h3C, 1'h1);
    read_check(8'h05, 1, 24'hFF0000);
  endtask
  // The erase frame lands while the first write is still busy and must be dropped.
  task automatic t_write_wrap();
    command(OP_SPECIAL, {SP_ENABLE, 7'h00}, 8'h00, 1'h0);
    command(OP_WRITE, 9'h0FF, 8'hA5, 1'h1);
    command(OP_ERASE, 9'h0FF, 8'h00, 1'h0);
    wait_ready();
    command(OP_WRITE, 9'h000, 8'h5A, 1'h1);
    wait_ready();
    command(OP_ERASE, 9'h000, 8'h00, 1'h0);
    wait_ready();
    read_check(8'hFF, 3, 24'hA5FFFF);
  endtask
  task automatic t_all();
    command(OP_SPECIAL, {SP_WRITE_ALL, 7'h00}, 8'h3C, 1'h1);
    wait_ready();
    command(OP_WRITE, 9'h080, 8'hC3, 1'h1);
    wait_ready();
    read_check(8'h7F, 2, 24'h3CC300);
    command(OP_SPECIAL, {SP_ERASE_ALL, 7'h00}, 8'h00, 1'h0);
    wait_ready();
    command(OP_SPECIAL, {SP_DISABLE, 7'h00}, 8'h00, 1'h0);
    command(OP_WRITE, 9'h180, 8'h00, 1'h1);
    read_check(8'h80, 1, 24'hFF0000);
  endtask
  // A reset in mid-run must drop the enable state, so the later write is refused.
  task automatic t_reset_again();
    command(OP_SPECIAL, {SP_ENABLE, 7'h00}, 8'h00, 1'h0);
    @(negedge sys_clk);
    rst = 1'h1;
    repeat (3) @(posedge link_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    repeat (40) @(negedge sys_clk);
    cmp_byte("port after second reset", 8'h80, reg_rd_data);
    command(OP_WRITE, 9'h010, 8'h00, 1'h1);
    read_check(8'h10, 1, 24'hFF0000);
  endtask
  // Reset spans several link clocks so both domains start clean.
  initial begin
    fail_count  = 0;
    checks_done = 0;
    rst         = 1'h1;
    repeat (6) @(posedge link_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    repeat (20) @(negedge sys_clk);
    t_reset_state();
    t_locked();
    t_write_wrap();
    t_all();
    t_reset_again();
    end_of_test();
  end
  // Watchdog sized above the expected run of about 75k cycles, yet short enough to end a hang quickly.
  initial begin
    repeat (95000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
